/* hw/psb_port.sv */
// pipelined burst static memory, 256K x 36, turnaround-free port
// Summary of operation
// - every synchronous input except the clock qualifier is registered on the rising clock edge
// - read data leaves through output registers, pipelined
// - clock qualifier high freezes all internal state except the sleep synchroniser, stretching the cycle
// - data drivers are synchronously off during a write data phase
// - reads and writes mix back to back, one word per cycle
// - no wait states at any supported bus rate up to 200 MHz
// - three synchronous chip selects plus an asynchronous output enable
// - writes self-timed, bytes gated by lane enables and write strobe
// - bursts step linear or interleaved per the ordering select
// - sleep request idles the array; stopped clock is tolerated
// - organised as 256K words of 36 bits
// - output drivers turn on and off by internal timing
`timescale 1ns/1ns
module psb_port (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [psb_pkg::ADDR_W-1:0] ADDR,
	input wire logic ADV_LOAD,
	input wire logic WRITE_N,
	input wire logic [psb_pkg::LANES-1:0] BYTE_LANE_WRITE_N,
	input wire logic CLOCK_QUALIFY_N,
	input wire logic CHIP_SELECT_FIRST_N,
	input wire logic CHIP_SELECT_SECOND,
	input wire logic CHIP_SELECT_THIRD_N,
	input wire logic OUT_ENABLE_N,
	input wire logic LINEAR_ORDER,
	input wire logic SLEEP_REQUEST,
	input wire logic [psb_pkg::DATA_W-1:0] DQ_IN,
	output logic [psb_pkg::DATA_W-1:0] DQ_OUT,
	output logic DQ_OE
);
	import psb_pkg::*;

	function automatic logic [BURST_W-1:0] burst_next(input logic [BURST_W-1:0] base,
		input logic [BURST_W-1:0] cnt, input logic lin);
		burst_next = lin ? base + cnt : base ^ cnt;
	endfunction : burst_next

	logic [DATA_W-1:0] mem [0:DEPTH-1];

	logic sleep_s;
	psb_sync u_sleep (
		.MCLK(MCLK),
		.RST(RST),
		.d(SLEEP_REQUEST),
		.q(sleep_s)
	);

	// input registers
	logic [ADDR_W-1:0] a_q;
	logic adv_q, we_n_q, sel_q, lin_q;
	logic [LANES-1:0] bw_n_q;
	// pipeline stages: command -> stage1 -> stage2 (data phase)
	psb_op_t op1_q, op2_q;
	logic [ADDR_W-1:0] addr1_q, addr2_q;
	logic [LANES-1:0] bw1_q, bw2_q;
	logic [ADDR_W-1:0] base_q;
	logic [BURST_W-1:0] cnt_q;
	psb_op_t last_q;
	logic [DATA_W-1:0] rd_q;
	logic drive_q;

	// clock qualifier is used unregistered; a high holds all but the sleep synchroniser
	wire run = ~CLOCK_QUALIFY_N;
	wire sel = ~CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND & ~CHIP_SELECT_THIRD_N;
	wire awake = ~sleep_s;

	// decode of the registered command
	wire load_cmd = sel_q & ~adv_q;
	wire cont_cmd = adv_q & (last_q != PSB_IDLE);
	wire [BURST_W-1:0] cnt_n = cnt_q + 2'h1;
	wire [BURST_W-1:0] low_b = burst_next(base_q[BURST_W-1:0], cnt_n, lin_q);
	psb_op_t op_new;
	assign op_new = !awake ? PSB_IDLE :
		load_cmd ? (we_n_q ? PSB_READ : PSB_WRITE) :
		cont_cmd ? last_q : PSB_IDLE;
	wire [ADDR_W-1:0] addr_new = load_cmd ? a_q : {base_q[ADDR_W-1:BURST_W], low_b};
	wire [LANES-1:0] bw_new = load_cmd ? ~bw_n_q : bw1_q;
	// the qualifier acts on the very edge it is sampled at, in every stage alike,
	// otherwise a held command would be replayed into the pipeline
	wire step = run;

	// command and select registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			a_q <= '0;
			adv_q <= 1'b0;
			we_n_q <= 1'b1;
			sel_q <= 1'b0;
		end else if (run) begin
			a_q <= ADDR;
			adv_q <= ADV_LOAD;
			we_n_q <= WRITE_N;
			sel_q <= sel;
		end
	end

	// lane enables and burst order registered alongside
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			lin_q <= 1'b0;
			bw_n_q <= '1;
		end else if (run) begin
			lin_q <= LINEAR_ORDER;
			bw_n_q <= BYTE_LANE_WRITE_N;
		end
	end

	// stage one operation and the op a burst continues
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			op1_q <= PSB_IDLE;
			last_q <= PSB_IDLE;
		end else if (step) begin
			op1_q <= op_new;
			last_q <= op_new;
		end
	end

	// stage two operation, the data phase
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			op2_q <= PSB_IDLE;
		end else if (step) begin
			op2_q <= op1_q;
		end
	end

	// stage one word address
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			addr1_q <= '0;
		end else if (step) begin
			addr1_q <= addr_new;
		end
	end

	// stage two word address
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			addr2_q <= '0;
		end else if (step) begin
			addr2_q <= addr1_q;
		end
	end

	// lane enables travel with the address
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bw1_q <= '0;
			bw2_q <= '0;
		end else if (step) begin
			bw1_q <= bw_new;
			bw2_q <= bw1_q;
		end
	end

	// burst origin and step count; the count wraps after four words
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			base_q <= '0;
			cnt_q <= BURST_RST;
		end else if (step && load_cmd) begin
			base_q <= a_q;
			cnt_q <= BURST_RST;
		end else if (step && cont_cmd) begin
			cnt_q <= cnt_n;
		end
	end

	// per-lane write strobes and read bypass selects
	wire wr_phase = step && (op2_q == PSB_WRITE);
	wire same_word = (addr2_q == addr1_q);
	wire [DATA_W-1:0] rd_word = mem[addr1_q];
	wire [LANES-1:0] lane_we;
	wire [LANES-1:0] lane_fwd;
	wire [DATA_W-1:0] rd_d;
	// a read issued right behind a write to the same word samples the array
	// on the edge the write lands, so the written lanes come from the bus
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_we[g] = wr_phase && bw2_q[g];
			assign lane_fwd[g] = lane_we[g] && same_word;
			assign rd_d[g*LANE_W +: LANE_W] = lane_fwd[g] ? DQ_IN[g*LANE_W +: LANE_W] : rd_word[g*LANE_W +: LANE_W];
		end
	endgenerate

	// write in the data phase; write data is on DQ_IN this cycle
	always_ff @(posedge MCLK) begin
		for (int i = 0; i < LANES; i++) begin
			if (lane_we[i]) begin
				mem[addr2_q][i*LANE_W +: LANE_W] <= DQ_IN[i*LANE_W +: LANE_W];
			end
		end
	end

	// read data registered so it appears in the data phase
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rd_q <= '0;
		end else if (step) begin
			rd_q <= rd_d;
		end
	end

	// drive_q follows the pipelined command, never the asynchronous enable
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			drive_q <= 1'b0;
		end else if (step) begin
			drive_q <= (op1_q == PSB_READ);
		end
	end

	// asynchronous enable only masks; normal timing is self-timed
	wire drive_ok = ~OUT_ENABLE_N;
	assign DQ_OUT = rd_q;
	assign DQ_OE = drive_q & drive_ok;
	// one word per cycle at the system clock, no wait insertion
endmodule : psb_port

/* hw/psb_pkg.sv */
// shared constants for the pipelined burst memory port
package psb_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DEPTH = 262144;
	localparam int BURST_W = 2;
	localparam int PIPE_LAT = 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MAX_FREQ_MHZ = 200;
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	typedef enum logic [1:0] {PSB_IDLE, PSB_READ, PSB_WRITE} psb_op_t;
endpackage : psb_pkg

/* hw/psb_sync.sv */
// three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/1ns
module psb_sync (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic d,
	output logic q
);
	import psb_pkg::*;
	logic [2:0] s_q;
	logic q_q;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s_q <= SYNC_RST;
			q_q <= 1'b0;
		end else begin
			s_q <= {s_q[1:0], d};
			if (s_q[1] == s_q[2]) begin
				q_q <= s_q[2];
			end
		end
	end
	assign q = q_q;
endmodule : psb_sync

/* tb/psb_host.sv */
// host side of the shared data lines
`timescale 1ns/1ns
module psb_host (
	input wire logic drive,
	input wire logic [psb_pkg::DATA_W-1:0] wd,
	input wire logic [psb_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	output logic [psb_pkg::DATA_W-1:0] dq_in
);
	// a clash goes unknown; a released bus never echoes stale data
	assign dq_in = drive ? (dq_oe ? 'x : wd) : dq_oe ? dq_out : ~dq_out;
endmodule : psb_host

/* tb/psb_sva.sv */
// pin assertions for the memory port
`timescale 1ns/1ns
module psb_sva (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic ADV_LOAD,
	input wire logic WRITE_N,
	input wire logic CLOCK_QUALIFY_N,
	input wire logic CHIP_SELECT_FIRST_N,
	input wire logic CHIP_SELECT_SECOND,
	input wire logic CHIP_SELECT_THIRD_N,
	input wire logic OUT_ENABLE_N,
	input wire logic SLEEP_REQUEST,
	input wire logic [psb_pkg::DATA_W-1:0] DQ_OUT,
	input wire logic DQ_OE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	wire q = !CLOCK_QUALIFY_N;
	wire ld = q && !ADV_LOAD;
	wire s = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
	sequence s_rd; !SLEEP_REQUEST [*5] ##0 ld && s && WRITE_N; endsequence
	sequence s_wr; ld && s && !WRITE_N ##1 q [*2]; endsequence
	property p_rd; s_rd ##1 q [*2] |=> DQ_OE == !OUT_ENABLE_N; endproperty
	a_rd: assert property (p_rd) else $error("read not driven");
	property p_wr; s_wr |=> !DQ_OE; endproperty
	a_wr: assert property (p_wr) else $error("driven in write");
	property p_bb; s_rd ##1 s_wr |-> DQ_OE == !OUT_ENABLE_N ##1 !DQ_OE; endproperty
	a_bb: assert property (p_bb) else $error("read then write");
	property p_cs; ld && !s ##1 q [*2] |=> !DQ_OE; endproperty
	a_cs: assert property (p_cs) else $error("unselected drive");
	property p_oe; OUT_ENABLE_N |-> !DQ_OE; endproperty
	a_oe: assert property (p_oe) else $error("enable ignored");
	property p_hd; CLOCK_QUALIFY_N |=> $stable(DQ_OUT); endproperty
	a_hd: assert property (p_hd) else $error("data moved");
	property p_ho; (CLOCK_QUALIFY_N && !OUT_ENABLE_N) ##1 !OUT_ENABLE_N |-> $stable(DQ_OE); endproperty
	a_ho: assert property (p_ho) else $error("drive moved");
	property p_zz; SLEEP_REQUEST [*5] ##0 ld ##1 q [*2] |=> !DQ_OE; endproperty
	a_zz: assert property (p_zz) else $error("sleep drive");
endmodule : psb_sva
bind psb_port psb_sva u_sva (.MCLK(MCLK), .RST(RST), .ADV_LOAD(ADV_LOAD), .WRITE_N(WRITE_N),
	.CLOCK_QUALIFY_N(CLOCK_QUALIFY_N), .CHIP_SELECT_FIRST_N(CHIP_SELECT_FIRST_N),
	.CHIP_SELECT_SECOND(CHIP_SELECT_SECOND), .CHIP_SELECT_THIRD_N(CHIP_SELECT_THIRD_N),
	.OUT_ENABLE_N(OUT_ENABLE_N), .SLEEP_REQUEST(SLEEP_REQUEST), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));

/* tb/tb.sv */
// bench: mixed traffic, lanes, stall, drivers off
`timescale 1ns/1ns
module tb;
	import psb_pkg::*;
	logic clk = 0, rst = 1, qn = 0, oen = 0, slp = 0, hoe = 0, wn = 1, cs = 0, adv = 0, lin = 1, oe;
	logic [3:0] bw = 4'hF;
	logic [ADDR_W-1:0] a = '0;
	logic [DATA_W-1:0] b = 36'h5_A0C3_1E77, hd = '0, din, dout, m [int];
	int error_cnt = 0, checks = 0, k [$];
	psb_port dut (.MCLK(clk), .RST(rst), .ADDR(a), .ADV_LOAD(adv), .WRITE_N(wn), .BYTE_LANE_WRITE_N(bw),
		.CLOCK_QUALIFY_N(qn), .CHIP_SELECT_FIRST_N(1'h0), .CHIP_SELECT_SECOND(cs), .CHIP_SELECT_THIRD_N(1'h0),
		.OUT_ENABLE_N(oen), .LINEAR_ORDER(lin), .SLEEP_REQUEST(slp), .DQ_IN(din), .DQ_OUT(dout), .DQ_OE(oe));
	psb_host host (.drive(hoe), .wd(hd), .dq_out(dout), .dq_oe(oe), .dq_in(din));
	always #5 clk = ~clk;
	task ck(logic [35:0] g, e);
		checks++;
		if (g !== e) $display("MISMATCH %0t %h %h", $time, g, e);
		error_cnt += (g !== e);
	endtask : ck
	// code: hundreds 1 read, 2 write, 3 unselected read; last two digits address
	task go(logic [3:0] l, bit st);
		int c;
		int j;
		bw = l;
		for (int i = 0; i < k.size() + 3; i++) begin
			@(negedge clk);
			if (st && i == 2) begin
				qn = 1;
				repeat (3) @(negedge clk);
				qn = 0;
			end
			c = i < k.size() ? k[i] : 0;
			j = i > 2 ? k[i - 3] : 0;
			cs = c / 100 % 3 != 0;
			wn = c / 100 != 2;
			a = ADDR_W'(c % 100);
			hoe = j / 100 == 2;
			hd = b ^ DATA_W'(j % 100);
			for (int n = 0; n < LANES; n++)
				if (hoe && !l[n]) m[j % 100][n * LANE_W +: LANE_W] = hd[n * LANE_W +: LANE_W];
			if (j / 100 != 0) ck(DATA_W'(oe), DATA_W'(j / 100 == 1 && !oen && !slp));
			if (j / 100 == 1 && !oen && !slp) ck(dout, m[j % 100]);
		end
	endtask : go
	task t_mix;
		k = '{205, 206, 207, 105, 106, 204, 107, 208, 108, 305};
		go(4'h0, 0);
	endtask : t_mix
	// four-word read bursts from word 9, linear then interleaved
	task t_burst;
		k = '{208, 209, 210, 211};
		go(4'h0, 0);
		for (int o = 0; o < 2; o++) begin
			lin = !o;
			for (int i = 0; i < 7; i++) begin
				@(negedge clk);
				hoe = 0;
				cs = i == 0;
				wn = 1;
				adv = i > 0 && i < 4;
				a = ADDR_W'(9);
				if (i > 2) ck(DATA_W'(oe), DATA_W'(1));
				if (i > 2) ck(dout, m[8 + (o ? 1 ^ (i - 3) : (i - 2) % 4)]);
			end
		end
		lin = 1;
		adv = 0;
	endtask : t_burst
	task t_lane;
		b = 36'h9_3C5A_0F12;
		k = '{205, 0, 0, 105};
		go(4'h5, 1);
	endtask : t_lane
	task t_off;
		oen = 1;
		go(4'hF, 0);
		{oen, slp} = 2'h1;
		repeat (6) @(negedge clk);
		go(4'hF, 0);
		slp = 0;
	endtask : t_off
	task results;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		#3000;
		error_cnt++;
		results;
	end
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_mix;
		t_lane;
		t_burst;
		t_off;
		results;
	end
endmodule : tb
